// ### core/bps_map.vh
`ifndef BPS_MAP_VH
`define BPS_MAP_VH
// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define BPS_CLK_MHZ 200
`define BPS_SS_CYCLES 12'h7FF
`define BPS_DEAD_NS 20
`define BPS_DEAD_CYC ((`BPS_DEAD_NS * `BPS_CLK_MHZ + 999) / 1000)
`define BPS_BLANK_NS 300
`define BPS_BLANK_CYC ((`BPS_BLANK_NS * `BPS_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// Voltage-select code limits
// ----------------------------------------
`define BPS_VSEL_W 5
`define BPS_VSEL_FLOAT 5'h1F
// ----------------------------------------
// Register map
// ----------------------------------------
`define BPS_REG_CTRL 4'h0
`define BPS_REG_STAT 4'h4
`define BPS_REG_VSEL 4'h8
`define BPS_CTRL_EN_BIT 0
`define BPS_CTRL_RESET 32'h00000000
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define BPS_ST_POR 3'h0
`define BPS_ST_IDLE 3'h1
`define BPS_ST_SOFT 3'h2
`define BPS_ST_RUN 3'h3
`define BPS_ST_OVP 3'h4
`endif

// ### core/bps_gate_drive.v
`timescale 1ns/10ps
`include "bps_map.vh"
// ----------------------------------------
// Non-overlapping gate driver
// ----------------------------------------
module bps_gate_drive
(
  input wire mclk_in, // System clock
  input wire reset_n_in, // Async reset, active low
  input wire enable_in, // Drivers allowed
  input wire want_high_in, // Requested high-side on
  output reg high_gate_out, // High-side gate
  output reg low_gate_out // Low-side gate
);

  reg [3:0] dead_q;
  reg [3:0] dead_d;
  reg high_d;
  reg low_d;

  // Dead time before either driver turns on
  always @*
  begin
    high_d = high_gate_out;
    low_d = low_gate_out;
    dead_d = dead_q;
    if (!enable_in)
    begin
      high_d = 1'b0;
      low_d = 1'b0;
      dead_d = 4'h0;
    end
    else if (want_high_in ? high_gate_out : low_gate_out)
      dead_d = 4'h0;
    else if (high_gate_out || low_gate_out)
    begin
      high_d = 1'b0;
      low_d = 1'b0;
      dead_d = 4'h0;
    end
    else if (dead_q < `BPS_DEAD_CYC)
      dead_d = dead_q + 4'h1;
    else
    begin
      high_d = want_high_in;
      low_d = ~want_high_in;
    end
  end

  // Gate registers
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      high_gate_out <= 1'b0;
      low_gate_out <= 1'b0;
      dead_q <= 4'h0;
    end
    else
    begin
      high_gate_out <= high_d;
      low_gate_out <= low_d;
      dead_q <= dead_d;
    end
  end

endmodule // bps_gate_drive

// ### core/bps_supervisor.v
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "bps_map.vh"
// How it works
// - Below upper supply threshold: reset, drivers off
// - Soft start needs supply, enable, valid code
// - Supply below lower threshold re-enters reset
// - Count soft-start cycles, then release amplifier
// - Range flag low during soft start
// - Over-voltage after soft start latches protection
// - Supply cycle or enable toggle clears latch
// - Invalid then valid code clears latch
// - Range flag follows outer window after start
// - Fast window forces full or zero duty
// - Ramp comparison pulse drives the gates
// - Dead time between the two drivers
// - Blank current sense after high-side turn-on
// - Over-current from sense comparator result
// - Over-current ends high side until next cycle
// - Re-entry needs the narrower band
module bps_supervisor
(
  input wire mclk_in, // System clock 200 MHz
  input wire reset_n_in, // Async reset, active low
  input wire cycle_start_in, // Switching-cycle start pulse
  input wire supply_above_upper_in, // Supply above upper threshold
  input wire supply_below_lower_in, // Supply below lower threshold
  input wire output_enable_input_in, // Output enable pin
  input wire [4:0] voltage_select_code_in, // Voltage-select pins
  input wire ramp_cmp_in, // Amplifier above ramp
  input wire fast_low_in, // Output below fast window
  input wire fast_high_in, // Output above fast window
  input wire ovp_cmp_in, // Output above over-voltage limit
  input wire outer_win_in, // Output inside outer window
  input wire inner_win_in, // Output inside re-entry band
  input wire current_limit_sense_input_in, // Drop above limit
  input wire [3:0] avs_address_in, // Avalon address
  input wire avs_read_in, // Avalon read
  input wire avs_write_in, // Avalon write
  input wire [31:0] avs_writedata_in, // Avalon write data
  output reg [31:0] avs_readdata_out, // Avalon read data
  output wire avs_waitrequest_out, // Avalon wait
  output wire high_gate_out, // High-side gate
  output wire low_gate_out, // Low-side gate
  output reg soft_start_clamp_out, // Amplifier clamped
  output reg output_in_range_flag_out, // Range flag pin
  output wire overvoltage_latch_mode_out // Protection latched
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  localparam SW = 14;
  wire [SW-1:0] raw_w;
  reg [SW-1:0] s1_q;
  reg [SW-1:0] s2_q;
  assign raw_w = {cycle_start_in, supply_above_upper_in,
    supply_below_lower_in, output_enable_input_in,
    voltage_select_code_in == `BPS_VSEL_FLOAT, ramp_cmp_in,
    fast_low_in, fast_high_in, ovp_cmp_in, outer_win_in,
    inner_win_in, current_limit_sense_input_in, 1'b0, 1'b0};

  // Two flops for each asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  wire cyc_lvl = s2_q[13];
  wire sup_up = s2_q[12];
  wire sup_lo = s2_q[11];
  wire en_pin = s2_q[10];
  wire code_bad = s2_q[9];
  wire ramp_s = s2_q[8];
  wire fast_lo = s2_q[7];
  wire fast_hi = s2_q[6];
  wire ovp_s = s2_q[5];
  wire outer_s = s2_q[4];
  wire inner_s = s2_q[3];
  wire oc_s = s2_q[2];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  reg [31:0] ctrl_q;
  reg rd_pend_q;
  wire sw_en = ctrl_q[`BPS_CTRL_EN_BIT];
  wire en_all = en_pin & sw_en;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [11:0] ss_q;
  reg ovp_q;

  // Reads take one wait cycle; writes are immediate
  assign avs_waitrequest_out = avs_read_in & ~rd_pend_q;

  // Bus slave registers
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl_q <= `BPS_CTRL_RESET;
      rd_pend_q <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end
    else
    begin
      rd_pend_q <= avs_read_in & ~rd_pend_q;
      if (avs_write_in && avs_address_in == `BPS_REG_CTRL)
        ctrl_q <= {31'h00000000, avs_writedata_in[0]};
      if (avs_read_in && !rd_pend_q)
      begin
        case (avs_address_in)
          `BPS_REG_CTRL: avs_readdata_out <= ctrl_q;
          `BPS_REG_STAT: avs_readdata_out <= {16'h0000, ss_q,
            ovp_q, output_in_range_flag_out, state_q[1:0]};
          `BPS_REG_VSEL: avs_readdata_out <= {27'h0000000,
            voltage_select_code_in};
          default: avs_readdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg en_prev_q;
  reg bad_seen_q;
  reg cyc_prev_q;
  wire en_toggle = en_all ^ en_prev_q;
  wire cyc_pulse = cyc_lvl & ~cyc_prev_q;

  // Power-on, soft start and protection sequencing
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `BPS_ST_POR:
        if (sup_up)
          state_d = `BPS_ST_IDLE;
      `BPS_ST_IDLE:
        if (en_all && !code_bad)
          state_d = `BPS_ST_SOFT;
      `BPS_ST_SOFT:
        if (!en_all || code_bad)
          state_d = `BPS_ST_IDLE;
        else if (ss_q == `BPS_SS_CYCLES && cyc_pulse)
          state_d = `BPS_ST_RUN;
      `BPS_ST_RUN:
        if (ovp_s)
          state_d = `BPS_ST_OVP;
        else if (!en_all || code_bad)
          state_d = `BPS_ST_IDLE;
      `BPS_ST_OVP:
        if (en_toggle)
          state_d = `BPS_ST_IDLE;
        else if (bad_seen_q && !code_bad)
          state_d = `BPS_ST_IDLE;
      default: state_d = `BPS_ST_POR;
    endcase
    if (sup_lo || (state_q == `BPS_ST_POR && !sup_up))
      state_d = `BPS_ST_POR;
  end

  // Sequencer registers and soft-start counter
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= `BPS_ST_POR;
      ss_q <= 12'h000;
      en_prev_q <= 1'b0;
      bad_seen_q <= 1'b0;
      cyc_prev_q <= 1'b0;
      ovp_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      en_prev_q <= en_all;
      cyc_prev_q <= cyc_lvl;
      ovp_q <= (state_d == `BPS_ST_OVP);
      if (state_q != `BPS_ST_SOFT)
        ss_q <= 12'h000;
      else if (cyc_pulse && ss_q != `BPS_SS_CYCLES)
        ss_q <= ss_q + 12'h001;
      if (state_q != `BPS_ST_OVP)
        bad_seen_q <= 1'b0;
      else if (code_bad)
        bad_seen_q <= 1'b1;
    end
  end

  assign overvoltage_latch_mode_out = ovp_q;

  // ----------------------------------------
  // Range flag
  // ----------------------------------------
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      output_in_range_flag_out <= 1'b0;
    else if (state_q != `BPS_ST_RUN || state_d != `BPS_ST_RUN)
      output_in_range_flag_out <= 1'b0;
    else if (!outer_s)
      output_in_range_flag_out <= 1'b0;
    else if (output_in_range_flag_out || inner_s)
      output_in_range_flag_out <= 1'b1;
  end

  // ----------------------------------------
  // Duty generation
  // ----------------------------------------
  reg oc_q;
  reg [6:0] blank_q;
  reg want_high;

  // Cycle-by-cycle current limit with blanking
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      oc_q <= 1'b0;
      blank_q <= 7'h00;
      soft_start_clamp_out <= 1'b1;
    end
    else
    begin
      soft_start_clamp_out <= (state_q != `BPS_ST_RUN);
      if (!high_gate_out)
        blank_q <= 7'h00;
      else if (blank_q < `BPS_BLANK_CYC)
        blank_q <= blank_q + 7'h01;
      if (cyc_pulse)
        oc_q <= 1'b0;
      else if (high_gate_out && blank_q >= `BPS_BLANK_CYC && oc_s)
        oc_q <= 1'b1;
    end
  end

  // Drive request from ramp, fast window and limits
  always @*
  begin
    want_high = ramp_s;
    if (fast_lo)
      want_high = 1'b1;
    if (fast_hi)
      want_high = 1'b0;
    if (oc_q || (oc_s && high_gate_out && blank_q >= `BPS_BLANK_CYC))
      want_high = 1'b0;
    if (state_q == `BPS_ST_OVP)
      want_high = 1'b0;
  end

  wire drv_en = (state_q == `BPS_ST_SOFT) || (state_q == `BPS_ST_RUN)
    || (state_q == `BPS_ST_OVP);

  // Gate sequencing
  bps_gate_drive u_gate
  (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .enable_in(drv_en),
    .want_high_in(want_high),
    .high_gate_out(high_gate_out),
    .low_gate_out(low_gate_out)
  );

endmodule // bps_supervisor

// ### verification/bps_sup_assertions.sv
`timescale 1ns/10ps
// ----
// Gate and flag checks
// ----
module bps_sup_chk
(
  input wire mclk_in, // Clock
  input wire reset_n_in, // Reset
  input wire supply_below_lower_in, // Low supply
  input wire fast_low_in, // Below window
  input wire fast_high_in, // Above window
  input wire ovp_cmp_in, // Over-voltage
  input wire inner_win_in, // Inner band
  input wire high_gate_out, // High gate
  input wire low_gate_out, // Low gate
  input wire soft_start_clamp_out, // Clamp
  input wire output_in_range_flag_out, // Range flag
  input wire overvoltage_latch_mode_out // Latch
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  AST_NO_OVERLAP: assert property (!(high_gate_out && low_gate_out))
    else $error("both gates on");
  AST_DEAD_HL: assert property ($fell(high_gate_out) |-> (!low_gate_out)[*4])
    else $error("low gate too soon");
  AST_DEAD_LH: assert property ($fell(low_gate_out) |-> (!high_gate_out)[*4])
    else $error("high gate too soon");
  AST_SS_FLAG: assert property (soft_start_clamp_out |-> !output_in_range_flag_out)
    else $error("flag high in soft start");
  AST_OVP_HOLD: assert property (overvoltage_latch_mode_out &&
    $past(overvoltage_latch_mode_out) |-> !high_gate_out && !output_in_range_flag_out)
    else $error("latch not holding outputs");
  AST_OVP_LOW: assert property ((overvoltage_latch_mode_out)[*8] |-> low_gate_out)
    else $error("low gate off in latch");
  AST_POR: assert property ((supply_below_lower_in)[*8] |->
    !high_gate_out && !low_gate_out && soft_start_clamp_out)
    else $error("low supply not in reset");
  AST_FAST_LOW: assert property ($rose(fast_low_in) && !soft_start_clamp_out &&
    !overvoltage_latch_mode_out |-> ##[1:12] high_gate_out)
    else $error("no full duty");
  AST_FAST_HIGH: assert property ($rose(fast_high_in) && !soft_start_clamp_out |->
    ##[1:12] (low_gate_out && !high_gate_out))
    else $error("no zero duty");
  AST_OVP_SYNC: assert property ($rose(overvoltage_latch_mode_out) |-> $past(ovp_cmp_in, 2))
    else $error("latch without cause");
  AST_FLAG_IN: assert property ($rose(output_in_range_flag_out) |-> $past(inner_win_in, 2))
    else $error("flag outside band");
  AST_OVP_CLR: assert property ($fell(overvoltage_latch_mode_out) |-> soft_start_clamp_out)
    else $error("no restart after clear");
endmodule // bps_sup_chk

bind bps_supervisor bps_sup_chk u_chk (.mclk_in, .reset_n_in,
  .supply_below_lower_in, .fast_low_in, .fast_high_in, .ovp_cmp_in,
  .inner_win_in, .high_gate_out, .low_gate_out, .soft_start_clamp_out,
  .output_in_range_flag_out, .overvoltage_latch_mode_out);

// ### verification/bps_fet_model.sv
`timescale 1ns/10ps
// ----
// Switch pair model
// ----
module bps_fet_model
(
  input wire high_gate_in, // High gate
  input wire low_gate_in, // Low gate
  input wire heavy_load_in, // Load above limit
  output wire drop_above_limit_out // Drain drop high
);
  // Drop seen while high side conducts; overlap shorts the rail
  assign drop_above_limit_out = high_gate_in & (heavy_load_in | low_gate_in);
endmodule // bps_fet_model

// ### verification/testbench.sv
`timescale 1ns/10ps
`include "bps_map.vh"
// ----
// Supervisor bench
// ----
module testbench;
  logic mclk_in = 0, reset_n_in = 0, cs = 0, sa = 0, sb = 0, en = 1;
  logic ramp = 0, fl = 0, fh = 0, overvoltage_latch_mode = 0, ow = 0, iw = 0, hv = 0;
  logic rd = 0, wr = 0, wt, hg, lg, cl, pg, ol, oc;
  logic [4:0] code = 5'h1F;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rdat, d;
  logic [20:0] ft = {3'h4, 3'h7, 3'h5, 3'h0, 3'h4, 3'h7, 3'h0};
  int err_total = 0, cmp_count = 0, tcnt = 0, ms, k;

  bps_supervisor dut (.mclk_in, .reset_n_in, .cycle_start_in(cs),
    .supply_above_upper_in(sa), .supply_below_lower_in(sb),
    .output_enable_input_in(en), .voltage_select_code_in(code),
    .ramp_cmp_in(ramp), .fast_low_in(fl), .fast_high_in(fh),
    .ovp_cmp_in(overvoltage_latch_mode), .outer_win_in(ow), .inner_win_in(iw),
    .current_limit_sense_input_in(oc), .avs_address_in(ad),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .high_gate_out(hg), .low_gate_out(lg), .soft_start_clamp_out(cl),
    .output_in_range_flag_out(pg), .overvoltage_latch_mode_out(ol));
  bps_fet_model fet (.high_gate_in(hg), .low_gate_in(lg),
    .heavy_load_in(hv), .drop_above_limit_out(oc));

  // Clock and hang guard
  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    tcnt <= tcnt + 1;
    if (tcnt == 90000)
    begin
      err_total++;
      give_verdict;
    end
  end

  task give_verdict;
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task w8(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task gates(input logic h, input logic l);
    chk("high_gate", hg, h);
    chk("low_gate", lg, l);
  endtask
  // Switching cycle starts
  task cyc(input int n);
    repeat (n)
    begin
      cs <= 1;
      w8(4);
      cs <= 0;
      w8(4);
    end
  endtask
  // Avalon transfer, entered just after a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    ad <= a;
    wr <= w;
    rd <= !w;
    wd <= v;
    @(posedge mclk_in);
    while (wt) @(posedge mclk_in);
    d = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge mclk_in);
  endtask
  task sst;
    bus(0, `BPS_REG_STAT, 0);
    chk("state", d[1:0], ms[1:0]);
  endtask
  task ss;
    cyc(2000);
    chk("clamp", cl, 1);
    cyc(60);
    chk("clamp", cl, 0);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'hCCEF));
    w8(4);
    reset_n_in <= 1;
    w8(20);
    gates(0, 0);
    chk("clamp", cl, 1);
    ms = `BPS_ST_POR;
    sst;
    bus(0, `BPS_REG_CTRL, 0);
    chk("ctrl", d, `BPS_CTRL_RESET);
    sa <= 1;
    w8(8);
    ms = `BPS_ST_IDLE;
    sst;
    code <= 5'($urandom % 31);
    w8(8);
    sst;
    bus(0, `BPS_REG_VSEL, 0);
    chk("code", d, {27'h0, code});
    bus(1, 4'hC, 32'hFFFFFFFF);
    bus(0, 4'hC, 0);
    chk("unmapped", d, 0);
    bus(1, `BPS_REG_CTRL, 32'h1);
    w8(8);
    ms = `BPS_ST_SOFT;
    sst;
    ss;
    ms = `BPS_ST_RUN;
    sst;
    repeat (4)
    begin
      ramp <= 1'($urandom);
      cyc(1);
      w8(8);
      gates(ramp, !ramp);
    end
    for (k = 0; k < 2; k++)
    begin
      ramp <= k[0];
      fl <= !k;
      fh <= k[0];
      w8(16);
      gates(!k, k[0]);
    end
    fh <= 0;
    ramp <= 0;
    w8(12);
    hv <= 1;
    ramp <= 1;
    cyc(1);
    w8(20);
    gates(1, 0);
    w8(60);
    gates(0, 1);
    hv <= 0;
    w8(8);
    gates(0, 1);
    cyc(1);
    w8(8);
    gates(1, 0);
    for (k = 6; k >= 0; k--)
    begin
      {ow, iw} <= ft[k*3+1 +: 2];
      w8(8);
      chk("flag", pg, ft[k*3]);
    end
    overvoltage_latch_mode <= 1;
    w8(16);
    overvoltage_latch_mode <= 0;
    gates(0, 1);
    w8(8);
    chk("latch", ol, 1);
    chk("flag", pg, 0);
    ms = `BPS_ST_OVP;
    sst;
    en <= 0;
    w8(8);
    en <= 1;
    w8(8);
    chk("latch", ol, 0);
    ms = `BPS_ST_SOFT;
    sst;
    ss;
    overvoltage_latch_mode <= 1;
    w8(16);
    overvoltage_latch_mode <= 0;
    chk("latch", ol, 1);
    code <= 5'h1F;
    w8(8);
    code <= 5'($urandom % 31);
    w8(8);
    chk("latch", ol, 0);
    chk("clamp", cl, 1);
    sa <= 0;
    sb <= 1;
    w8(12);
    gates(0, 0);
    ms = `BPS_ST_POR;
    sst;
    sb <= 0;
    w8(8);
    sst;
    give_verdict;
  end
endmodule // testbench
